// file: include/asr_map.svh
// Named offsets, field positions, codes and reset values of the serial readout block
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// APB byte offsets
`define ASR_APB_OWC      8'h00
`define ASR_APB_IPC      8'h04
`define ASR_APB_OPC      8'h08
`define ASR_APB_CHAIN    8'h0C
`define ASR_APB_PATTERN  8'h10
`define ASR_APB_STATUS   8'h14
`define ASR_APB_LASTCMD  8'h18

// Addresses of the halfwords reachable by serial commands
`define ASR_SREG_IPC     8'h08
`define ASR_SREG_OPC     8'h0C
`define ASR_SREG_OWC     8'h10

// Command word fields and opcodes
`define ASR_CMD_OP       31:27
`define ASR_CMD_SUB      26:25
`define ASR_CMD_ADDR     23:16
`define ASR_CMD_DATA     15:0
`define ASR_OP_READ_HW   5'h19
`define ASR_OP_READ_B    5'h09
`define ASR_OP_WRITE     5'h1A
`define ASR_WR_HI_ONLY   2'h1
`define ASR_WR_LO_ONLY   2'h2
`define ASR_WR_NONE      2'h3

// Clock count of a full frame
`define ASR_FULL_FRAME   6'h20

// Chip select synchroniser starts at the idle level, so leaving reset is no frame end
`define ASR_CS_SYNC_IDLE 3'h7
`define ASR_CS_LVL_IDLE  1'b1

// output_word_control fields
`define ASR_OWC_PAT_FIX  2
`define ASR_OWC_PAR      3
`define ASR_OWC_RANGE    8
`define ASR_OWC_INALM    10
`define ASR_OWC_SUPALM   11
`define ASR_OWC_CHAIN    12
`define ASR_OWC_MASK     16'h1F0F

// input_port_control and output_port_control fields
`define ASR_IPC_FMT      1:0
`define ASR_IPC_MASK     8'h03
`define ASR_OPC_SRC      4

// Field widths in the packed conversion word
`define ASR_W_RES        6'h0C
`define ASR_W_CHAIN      6'h04
`define ASR_W_ALM        6'h02
`define ASR_W_RANGE      6'h04

`endif

// file: include/asr_pkg.sv
// Types shared by the serial readout block
package asr_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } asr_apb_req_t;

  typedef struct packed {
    logic [11:0] result;
    logic [1:0]  supply_alarm;
    logic [1:0]  input_alarm;
    logic [3:0]  range_code;
  } asr_sample_t;

  typedef struct packed {
    logic [2:0]  cs_s;
    logic        cs_lvl;
    logic [15:0] owc;
    logic [7:0]  ipc;
    logic [7:0]  opc;
    logic [3:0]  chain;
    logic [31:0] pattern;
    logic        rd_next;
    logic [31:0] rd_word;
    logic [31:0] word;
    logic [15:0] frames;
    logic [7:0]  short_frames;
    logic [5:0]  last_len;
    logic [31:0] last_cmd;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } asr_core_t;

  typedef struct packed {
    logic [31:0] shin;
    logic [5:0]  cnt;
  } asr_cap_t;

  typedef struct packed {
    logic       first;
    logic [5:0] idx;
  } asr_lnc_t;

endpackage

// file: verilog/asr_readout_top.sv
// Serial readout and format control with APB register access
//
// The register offsets and register access over APB are this design's own decisions.
`include "asr_map.svh"
`timescale 1ns/100ps
`default_nettype none

// **********************************************************************
// Frame start flag: set while chip select is high
// **********************************************************************
module asr_frame_open (
  input  wire logic cap_clk,
  input  wire logic presetn,
  input  wire logic cs_n,
  output var  logic open_r
);
  logic open_nxt;

  always_comb begin
    open_nxt = 1'b0;
  end

  always_ff @(posedge cap_clk or negedge presetn or posedge cs_n) begin
    if (!presetn || cs_n) begin
      open_r <= 1'b1;
    end else begin
      open_r <= open_nxt;
    end
  end
endmodule

// **********************************************************************
// Input shift register and clock counter on the capture edge
// **********************************************************************
module asr_link_capture (
  input  wire logic              cap_clk,
  input  wire logic              presetn,
  input  wire logic              open,
  input  wire logic              sdi,
  output var  asr_pkg::asr_cap_t cap_r
);
  asr_pkg::asr_cap_t cap_nxt;

  // Not cleared by chip select, so the core can read it after the frame
  always_comb begin
    cap_nxt      = cap_r;
    cap_nxt.shin = {cap_r.shin[30:0], sdi};
    if (open) begin
      cap_nxt.cnt = 6'h01;
    end else if (cap_r.cnt != `ASR_FULL_FRAME) begin
      cap_nxt.cnt = cap_r.cnt + 6'h01;
    end
  end

  always_ff @(posedge cap_clk or negedge presetn) begin
    if (!presetn) begin
      cap_r <= '0;
    end else begin
      cap_r <= cap_nxt;
    end
  end
endmodule

// **********************************************************************
// Output bit index, stepped on the launch edge
// **********************************************************************
module asr_link_launch (
  input  wire logic              launch_clk,
  input  wire logic              presetn,
  input  wire logic              cs_n,
  input  wire logic              cpha,
  output var  asr_pkg::asr_lnc_t lnc_r
);
  asr_pkg::asr_lnc_t lnc_nxt;

  always_comb begin
    lnc_nxt       = lnc_r;
    lnc_nxt.first = 1'b0;
    // Late-launch formats put the MSB out on the first edge, so no step there
    if (!(cpha && lnc_r.first) && lnc_r.idx != `ASR_FULL_FRAME) begin
      lnc_nxt.idx = lnc_r.idx + 6'h01;
    end
  end

  always_ff @(posedge launch_clk or negedge presetn or posedge cs_n) begin
    if (!presetn || cs_n) begin
      lnc_r <= '{first: 1'b1, idx: 6'h00};
    end else begin
      lnc_r <= lnc_nxt;
    end
  end
endmodule

// **********************************************************************
// Top: APB registers, frame decode and output word build
// **********************************************************************
module asr_readout_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  input  wire logic [11:0] conv_result,
  input  wire logic [1:0]  supply_alarm,
  input  wire logic [1:0]  input_alarm,
  input  wire logic [3:0]  range_code,
  output var  logic        serial_output_lines,
  output var  logic        source_sync_readout
);
  asr_pkg::asr_core_t    r;
  asr_pkg::asr_core_t    n;
  asr_pkg::asr_apb_req_t req;
  asr_pkg::asr_sample_t  smp;
  asr_pkg::asr_cap_t     cap;
  asr_pkg::asr_lnc_t     lnc;
  logic                  open;
  logic                  cap_fall;
  logic                  cpha;
  logic                  cap_clk;
  logic                  launch_clk;
  logic                  frame_end;
  logic [4:0]            op;
  logic [1:0]            sub;
  logic [7:0]            saddr;
  logic [7:0]            haddr;
  logic [15:0]           sdata;
  logic [15:0]           hw;
  logic                  apb_hit;
  logic                  apb_ro;
  logic [31:0]           apb_rd;

  // Flags follow the result in fixed order, each packed directly below the last
  function automatic logic [31:0] asr_pack(input logic [15:0]          owc,
                                           input logic [3:0]           chain,
                                           input asr_pkg::asr_sample_t s);
    logic [31:0] acc;
    logic [5:0]  used;
    logic        fpar;
    acc  = {s.result, 20'h00000};
    used = `ASR_W_RES;
    fpar = 1'b0;
    if (owc[`ASR_OWC_CHAIN]) begin
      acc  = acc | ({chain, 28'h0000000} >> used);
      used = used + `ASR_W_CHAIN;
      fpar = fpar ^ (^chain);
    end
    if (owc[`ASR_OWC_SUPALM]) begin
      acc  = acc | ({s.supply_alarm, 30'h00000000} >> used);
      used = used + `ASR_W_ALM;
      fpar = fpar ^ (^s.supply_alarm);
    end
    if (owc[`ASR_OWC_INALM]) begin
      acc  = acc | ({s.input_alarm, 30'h00000000} >> used);
      used = used + `ASR_W_ALM;
      fpar = fpar ^ (^s.input_alarm);
    end
    if (owc[`ASR_OWC_RANGE]) begin
      acc  = acc | ({s.range_code, 28'h0000000} >> used);
      used = used + `ASR_W_RANGE;
      fpar = fpar ^ (^s.range_code);
    end
    // Parity: upper bit covers the result, lower bit the appended flags
    if (owc[`ASR_OWC_PAR]) begin
      acc = acc | ({^s.result, fpar, 30'h00000000} >> used);
    end
    return acc;
  endfunction

  // Halfword view of the serially addressed registers; odd byte is the upper one
  function automatic logic [15:0] asr_hw_read(input logic [7:0]         a,
                                              input asr_pkg::asr_core_t c);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      `ASR_SREG_IPC: v = {8'h00, c.ipc};
      `ASR_SREG_OPC: v = {8'h00, c.opc};
      `ASR_SREG_OWC: v = c.owc;
      default:       v = 16'h0000;
    endcase
    return v;
  endfunction

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign smp = '{result: conv_result, supply_alarm: supply_alarm,
                 input_alarm: input_alarm, range_code: range_code};

  // **********************************************************************
  // Link clocking
  // **********************************************************************
  // Format only changes while the link is idle; a mode change can leave one
  // spurious edge, which the frame-open flag absorbs at the next frame.
  assign cpha       = r.ipc[0];
  assign cap_fall   = r.ipc[0] ^ r.ipc[1];
  assign cap_clk    = sclk ^ cap_fall;
  assign launch_clk = ~cap_clk;

  asr_frame_open u_open (
    .cap_clk (cap_clk),
    .presetn (presetn),
    .cs_n    (cs_n),
    .open_r  (open)
  );

  asr_link_capture u_cap (
    .cap_clk (cap_clk),
    .presetn (presetn),
    .open    (open),
    .sdi     (sdi),
    .cap_r   (cap)
  );

  asr_link_launch u_lnc (
    .launch_clk (launch_clk),
    .presetn    (presetn),
    .cs_n       (cs_n),
    .cpha       (cpha),
    .lnc_r      (lnc)
  );

  // The word is held steady by the core for the whole frame; past bit 0 the line reads low
  assign serial_output_lines = lnc.idx[5] ? 1'b0 : r.word[~lnc.idx[4:0]];
  assign prdata              = r.prdata;
  assign pready              = r.pready;
  assign pslverr             = r.pslverr;
  assign source_sync_readout = r.opc[`ASR_OPC_SRC];

  // **********************************************************************
  // APB decode
  // **********************************************************************
  always_comb begin
    apb_hit = 1'b1;
    apb_ro  = 1'b0;
    apb_rd  = 32'h00000000;
    case (req.paddr)
      `ASR_APB_OWC:     apb_rd = {16'h0000, r.owc};
      `ASR_APB_IPC:     apb_rd = {24'h000000, r.ipc};
      `ASR_APB_OPC:     apb_rd = {24'h000000, r.opc};
      `ASR_APB_CHAIN:   apb_rd = {28'h0000000, r.chain};
      `ASR_APB_PATTERN: apb_rd = r.pattern;
      `ASR_APB_STATUS: begin
        apb_rd = {r.frames, r.short_frames, 2'h0, r.last_len};
        apb_ro = 1'b1;
      end
      `ASR_APB_LASTCMD: begin
        apb_rd = r.last_cmd;
        apb_ro = 1'b1;
      end
      default:          apb_hit = 1'b0;
    endcase
  end

  // **********************************************************************
  // Core next state
  // **********************************************************************
  always_comb begin
    n         = r;
    op        = cap.shin[`ASR_CMD_OP];
    sub       = cap.shin[`ASR_CMD_SUB];
    saddr     = cap.shin[`ASR_CMD_ADDR];
    haddr     = {saddr[7:1], 1'b0};
    sdata     = cap.shin[`ASR_CMD_DATA];
    hw        = asr_hw_read(haddr, r);

    // Chip select: three stages, a change counts once stages two and three agree
    n.cs_s = {r.cs_s[1:0], cs_n};
    if (r.cs_s[1] == r.cs_s[2]) begin
      n.cs_lvl = r.cs_s[2];
    end
    frame_end = n.cs_lvl & ~r.cs_lvl;

    // APB: answer prepared in setup, presented through the access phase
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    n.prdata  = 32'h00000000;
    if (req.psel && !req.penable) begin
      n.pready  = 1'b1;
      n.pslverr = !apb_hit || (req.pwrite && apb_ro);
      n.prdata  = req.pwrite ? 32'h00000000 : apb_rd;
    end
    if (req.psel && req.penable && r.pready && req.pwrite && !r.pslverr) begin
      case (req.paddr)
        `ASR_APB_OWC:     n.owc = req.pwdata[15:0] & `ASR_OWC_MASK;
        `ASR_APB_IPC:     n.ipc = req.pwdata[7:0] & `ASR_IPC_MASK;
        `ASR_APB_OPC:     n.opc = req.pwdata[7:0];
        `ASR_APB_CHAIN:   n.chain = req.pwdata[3:0];
        `ASR_APB_PATTERN: n.pattern = req.pwdata;
        default:          n.pattern = r.pattern;
      endcase
    end

    // Frame end: the link is quiet, its captured word and count are stable
    if (frame_end) begin
      n.frames   = r.frames + 16'h0001;
      n.last_len = cap.cnt;
      n.last_cmd = cap.shin;
      n.rd_next  = 1'b0;
      if (cap.cnt == `ASR_FULL_FRAME) begin
        case (op)
          `ASR_OP_READ_HW: begin
            n.rd_next = 1'b1;
            n.rd_word = {hw, 16'h0000};
          end
          `ASR_OP_READ_B: begin
            n.rd_next = 1'b1;
            n.rd_word = {(saddr[0] ? hw[15:8] : hw[7:0]), 24'h000000};
          end
          `ASR_OP_WRITE: begin
            if (sub != `ASR_WR_NONE) begin
              case (haddr)
                `ASR_SREG_IPC: begin
                  if (sub != `ASR_WR_HI_ONLY) begin
                    n.ipc = sdata[7:0] & `ASR_IPC_MASK;
                  end
                end
                `ASR_SREG_OPC: begin
                  if (sub != `ASR_WR_HI_ONLY) begin
                    n.opc = sdata[7:0];
                  end
                end
                `ASR_SREG_OWC: begin
                  if (sub != `ASR_WR_HI_ONLY) begin
                    n.owc[7:0] = sdata[7:0] & 8'(`ASR_OWC_MASK);
                  end
                  if (sub != `ASR_WR_LO_ONLY) begin
                    n.owc[15:8] = sdata[15:8] & 8'(`ASR_OWC_MASK >> 8);
                  end
                end
                default: n.owc = n.owc;
              endcase
            end
          end
          default: n.rd_next = 1'b0;
        endcase
      end else begin
        // Short frame: command dropped, the bits already shifted were valid
        n.short_frames = r.short_frames + 8'h01;
      end
    end

    // Word for the next frame is refreshed only while the link is idle
    if (n.cs_lvl) begin
      if (n.owc[`ASR_OWC_PAT_FIX]) begin
        n.word = n.pattern;
      end else if (n.rd_next) begin
        n.word = n.rd_word;
      end else begin
        n.word = asr_pack(n.owc, n.chain, smp);
      end
    end
  end

  // All fields but the chip select sync clear on reset, which selects format 0 for reads and writes;
  // the chip select sync starts high so reset release is not counted as a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.cs_s   <= `ASR_CS_SYNC_IDLE;
      r.cs_lvl <= `ASR_CS_LVL_IDLE;
    end else begin
      r <= n;
    end
  end
endmodule

`default_nettype wire

// file: verif/asr_readout_asserts.sv
// Port checker for the serial readout top, bound below
`timescale 1ns/100ps
`default_nettype none

// ********
// APB answer and configuration checks
// ********
module asr_readout_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cs_n,
  input wire logic        source_sync_readout
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ack_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  ack_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no zero-wait answer after setup");
  ack_cause_a: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
    else $error("pready without a setup cycle");
  err_with_ack_a: assert property (pslverr |-> pready)
    else $error("pslverr outside the answer cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero between answers");
  ro_refuse_a: assert property (psel && penable && pwrite && paddr inside {8'h14, 8'h18}
    |-> pslverr)
    else $error("write to read-only place not refused");
  unaligned_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  reset_idle_a: assert property ($rose(presetn) |-> !pready && !source_sync_readout)
    else $error("outputs not idle after reset");
  src_cause_a: assert property ($changed(source_sync_readout)
    |-> $past(psel && penable && pwrite && paddr == 8'h08) || (cs_n && !$past(cs_n, 5)))
    else $error("readout select changed without a write");
endmodule

bind asr_readout_top asr_readout_asserts chk (
  .pclk                (pclk),
  .presetn             (presetn),
  .psel                (psel),
  .penable             (penable),
  .pwrite              (pwrite),
  .paddr               (paddr),
  .prdata              (prdata),
  .pready              (pready),
  .pslverr             (pslverr),
  .cs_n                (cs_n),
  .source_sync_readout (source_sync_readout)
);

`default_nettype wire

// file: verif/asr_host_model.sv
// Behavioural host controller that frames serial transfers
`timescale 1ns/100ps
`default_nettype none

module asr_host_model (
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic sdi,
  input  wire logic sdo
);
  logic [31:0] rx;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
    rx   = 32'h0;
  end

  // Clock stands still outside frames; n above 32 is never asked for
  task automatic frame(input logic [1:0] fmt, input int n, input logic [31:0] cmd);
    logic ph;
    ph = fmt[0];
    sclk = fmt[1];
    #7 cs_n = 1'b0;
    rx = 32'h0;
    #170;
    for (int i = 0; i < n; i++) begin
      if (!ph)
        sdi = cmd[31-i];
      #24 sclk = ~sclk;
      if (!ph)
        rx = {rx[30:0], sdo};
      if (ph)
        sdi = cmd[31-i];
      #24 sclk = ~sclk;
      if (ph)
        rx = {rx[30:0], sdo};
    end
    #24 cs_n = 1'b1;
    // Released line shows no stale bit
    sdi = ~sdi;
    #264;
  endtask
endmodule

`default_nettype wire

// file: verif/tb_adc_serial_readout_config.sv
// Self-checking bench for the serial readout block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module tb_adc_serial_readout_config;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        sclk, cs_n, sdi, sdo, ssr;
  logic [11:0] res;
  logic [1:0]  sup, inp, f;
  logic [3:0]  rng, chain;
  logic [4:0]  en_tbl[5];
  int          n_errors = 0, tests_run = 0, cycles = 0;

  asr_readout_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .conv_result(res),
    .supply_alarm(sup), .input_alarm(inp), .range_code(rng),
    .serial_output_lines(sdo), .source_sync_readout(ssr));
  asr_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop;
    end
  end

  // Entered just after a rising edge; the answer is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the cycle watchdog ends a wait for an answer that never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic fr(input logic [1:0] fm, input int n, input logic [31:0] c);
    host.frame(fm, n, c);
    @(posedge pclk);
  endtask

  function automatic logic [31:0] cmd(input logic [4:0] op, input logic [7:0] a,
                                      input logic [15:0] d);
    cmd = {op, 3'h0, a, d};
  endfunction

  function automatic logic [31:0] owc(input logic [4:0] en);
    owc = 32'({en[4], en[3], en[2], 1'b0, en[1], 4'h0, en[0], 3'h0});
  endfunction

  // Enabled fields stack below the result with no gaps
  function automatic logic [31:0] pack(input logic [4:0] en);
    logic [31:0] w;
    logic [31:0] v[5];
    int          wd[5];
    int          p;
    logic        fl;
    wd = '{4, 2, 2, 4, 2};
    v = '{32'(chain), 32'(sup), 32'(inp), 32'(rng), 32'h0};
    w = {res, 20'h0};
    p = 20;
    fl = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (i == 4)
        v[4] = {30'h0, ^res, fl};
      if (en[4-i]) begin
        p -= wd[i];
        w |= v[i] << p;
        fl ^= ^v[i];
      end
    end
    pack = w;
  endfunction

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    res = 12'hA5C;
    sup = 2'h2;
    inp = 2'h1;
    rng = 4'h6;
    chain = 4'hA;
    en_tbl = '{5'h1F, 5'h0B, 5'h00, 5'h14, 5'h01};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h05, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, 8'h14, 32'hFFFF);
    `CHK(err, 1'b1)
    apb(1'b1, 8'h08, 32'h10);
    `CHK(ssr, 1'b1)
    apb(1'b1, 8'h08, 32'h0);
    `CHK(ssr, 1'b0)
    apb(1'b1, 8'h0C, 32'(chain));
    for (int i = 0; i < 5; i++) begin
      res <= res + 12'h111;
      apb(1'b1, 8'h00, owc(en_tbl[i]));
      fr(2'h0, 32, 32'h0);
      `CHK(host.rx, pack(en_tbl[i]))
    end
    fr(2'h0, 32, cmd(5'h1A, 8'h10, 16'h1D08));
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h1D08)
    apb(1'b0, 8'h18, 32'h0);
    `CHK(q, cmd(5'h1A, 8'h10, 16'h1D08))
    fr(2'h0, 32, cmd(5'h19, 8'h10, 16'h0));
    fr(2'h0, 32, cmd(5'h09, 8'h11, 16'h0));
    `CHK(host.rx, 32'h1D08_0000)
    fr(2'h0, 32, cmd(5'h09, 8'h10, 16'h0));
    `CHK(host.rx, 32'h1D00_0000)
    fr(2'h0, 32, 32'h0);
    `CHK(host.rx, 32'h0800_0000)
    fr(2'h0, 20, cmd(5'h1A, 8'h10, 16'h0));
    `CHK(host.rx, pack(5'h1F) >> 12)
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h1D08)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(q, 32'h000B_0114)
    apb(1'b1, 8'h10, 32'hC3A5_0F1E);
    apb(1'b1, 8'h00, 32'h1D0C);
    fr(2'h0, 32, cmd(5'h19, 8'h10, 16'h0));
    fr(2'h0, 32, 32'h0);
    `CHK(host.rx, 32'hC3A5_0F1E)
    apb(1'b1, 8'h00, 32'h1D08);
    f = 2'h0;
    for (int k = 1; k < 4; k++) begin
      fr(f, 32, cmd(5'h1A, 8'h08, 16'(k)));
      f = 2'(k);
      fr(f, 32, cmd(5'h19, 8'h08, 16'h0));
      fr(f, 32, 32'h0);
      `CHK(host.rx, {16'(k), 16'h0})
      apb(1'b0, 8'h04, 32'h0);
      `CHK(q, 32'(k))
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(q, 32'h0)
    fr(2'h0, 32, 32'h0);
    `CHK(host.rx, pack(5'h00))
    apb(1'b0, 8'h14, 32'h0);
    `CHK(q, 32'h0001_0020)
    report_and_stop;
  end
endmodule

`default_nettype wire
